// [flash_self_program_pkg.sv]
// constants and types shared by the flash self-programming control block
package flash_self_program_pkg;

   // ==========================================================
   // bus register map (byte addresses)
   localparam logic [7:0] CSR_OFFSET      = 8'h00;
   localparam logic [7:0] FUSE_OFFSET     = 8'h04;
   localparam logic [7:0] STATUS_OFFSET   = 8'h08;

   // ==========================================================
   // control register bit positions
   localparam int BIT_READY_INT_ENABLE   = 7;
   localparam int BIT_REGION_BUSY        = 6;
   localparam int BIT_SIGNATURE_READ     = 5;
   localparam int BIT_REGION_REENABLE    = 4;
   localparam int BIT_LOCK_SET           = 3;
   localparam int BIT_PAGE_WRITE         = 2;
   localparam int BIT_PAGE_ERASE         = 1;
   localparam int BIT_PROGRAM_ENABLE     = 0;

   // accepted low-five-bit command patterns
   localparam logic [4:0] CMD_SIGNATURE  = 5'h00; // internal code: fill pattern plus bit 5
   localparam logic [4:0] CMD_REENABLE   = 5'h11;
   localparam logic [4:0] CMD_LOCK_SET   = 5'h09;
   localparam logic [4:0] CMD_PAGE_WRITE = 5'h05;
   localparam logic [4:0] CMD_PAGE_ERASE = 5'h03;
   localparam logic [4:0] CMD_FILL       = 5'h01;

   // ==========================================================
   // flash geometry
   localparam int PC_WIDTH        = 16;
   localparam int WORD_SEL_WIDTH  = 7;
   localparam int PAGE_WIDTH      = 9;
   localparam int PAGE_WORDS      = 128;
   localparam int PTR_WORD_LSB    = 1;
   localparam int PTR_WORD_MSB    = 7;
   localparam int PTR_PAGE_LSB    = 8;
   localparam int PTR_PAGE_MSB    = 16;
   localparam logic [15:0] RWW_LAST_WORD  = 16'hEFFF;
   localparam logic [15:0] NO_READ_WHILE_WRITE_REGION_FIRST_WORD = 16'hF000;

   // boot section start per fuse code
   localparam logic [15:0] BOOT_START_11 = 16'hFE00;
   localparam logic [15:0] BOOT_START_10 = 16'hFC00;
   localparam logic [15:0] BOOT_START_01 = 16'hF800;
   localparam logic [15:0] BOOT_START_00 = 16'hF000;
   localparam logic [12:0] BOOT_WORDS_11 = 13'h0200;
   localparam logic [12:0] BOOT_WORDS_10 = 13'h0400;
   localparam logic [12:0] BOOT_WORDS_01 = 13'h0800;
   localparam logic [12:0] BOOT_WORDS_00 = 13'h1000;

   // ==========================================================
   // timing
   localparam int CLK_MHZ         = 50;
   localparam int ARM_WINDOW_STORE = 4;
   localparam int ARM_WINDOW_LOAD  = 3;
   localparam logic [2:0] ARM_CNT_LOAD = 3'h4;
   localparam logic [7:0] LOCK_RESET   = 8'hFF;

   typedef enum logic [1:0] {
      IDLE_ST = 2'b00,
      ARMED_ST = 2'b01,
      BUSY_ST = 2'b11
   } op_state_type;

endpackage

// [flash_self_program_control.sv]
// flash self-programming control: command register, arming window, flash op sequencing
//
// What this block does
// [R1] boot section size and start from the two boot-size fuse bits
// [R2] words 0000-EFFF are read-while-write region, F000-FFFF no-read-while-write
// [R3] sixteen-bit program word counter addresses flash
// [R4] 128-word pages, word select from pointer bits 7 to 1
// [R5] erase and write page number from pointer bits 16 to 8
// [R6] software keeps word-select bits zero for page write
// [R7] pointer bit 0 zero for stores, byte select for loads
// [R8] ready interrupt requested while enabled, global flag set, program-enable clear
// [R9] erase or write to region sets busy flag and blocks region reads
// [R10] busy flag cleared by re-enable after completion or by buffer fill
// [R11] signature arm: load returns signature byte, store does nothing
// [R12] re-enable arm: store re-enables region, ignored while operation runs
// [R13] re-enable written during buffer fill aborts fill, discards data
// [R14] lock-set arm: store sets boot lock bits from low data register
// [R15] lock-set arm: load returns lock or fuse byte by pointer bit 0
// [R16] page-write arm: store writes temporary buffer to addressed page
// [R17] page-erase arm: store erases addressed page
// [R18] core stalled during erase or write of no-read-while-write region
// [R19] no store within four cycles clears program-enable and command bits
// [R20] program-enable only: store puts data word in temporary buffer
// [R21] program-enable clears on store completion, held during erase and write
// [R22] only six command patterns accepted, others ignored
// [R23] software runs one store operation at a time
// [R24] core strobes store and load with pointer and data, block answers
//
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
module flash_self_program_control
   import flash_self_program_pkg::*;
#(
   parameter int OP_CYCLES = 64
) (
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst,
   // axi4-lite slave
   input  wire logic [7:0]           s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   input  wire logic [7:0]           s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   // core instruction strobes
   input  wire logic                 store_program_instr,
   input  wire logic                 load_program_instr,
   input  wire logic [PTR_PAGE_MSB:0] ptr,
   input  wire logic [7:0]           low_data_reg,
   input  wire logic [7:0]           high_data_reg,
   input  wire logic                 global_int_flag,
   input  wire logic [PC_WIDTH-1:0]  fetch_addr,
   output logic                      core_stall,
   output logic [7:0]                load_data,
   output logic                      load_valid,
   output logic                      ready_irq,
   output logic                      region_read_block,
   // flash array side
   output logic                      flash_erase,
   output logic                      flash_write,
   output logic [PAGE_WIDTH-1:0]     page_number_bits,
   output logic                      buf_write,
   output logic [WORD_SEL_WIDTH-1:0] word_in_page_bits,
   output logic [15:0]               buf_data,
   output logic                      buf_discard,
   // fuse and signature sources
   input  wire logic [7:0]           signature_byte,
   input  wire logic [7:0]           fuse_low_byte,
   input  wire logic [7:0]           fuse_high_byte
);

   // ==========================================================
   // state
   op_state_type              state_r;
   logic [4:0]                cmd_r;
   logic                      int_en_r;
   logic                      busy_r;
   logic [2:0]                arm_cnt_r;
   logic                      fill_act_r;
   logic                      op_no_read_while_write_region_r;
   logic [$clog2(OP_CYCLES+1)-1:0] op_cnt_r;
   logic [7:0]                lock_r;
   logic [1:0]                boot_fuse_r;
   logic [15:0]               boot_start;
   logic [12:0]               boot_words;
   logic [PC_WIDTH-1:0]       op_word;
   logic                      op_no_read_while_write_region;
   logic                      csr_wr;
   logic [4:0]                cmd_in;
   logic                      sig_sel;
   logic                      cmd_legal;
   logic                      armed;
   logic                      op_done;
   logic                      aw_seen_r;
   logic                      w_seen_r;
   logic [7:0]                awaddr_r;
   logic [31:0]               wdata_r;
   logic [3:0]                wstrb_r;
   logic                      wr_go;

   // ==========================================================
   // boot section from fuses
   always_comb begin
      case (boot_fuse_r) // R1
         2'b11: begin boot_start = BOOT_START_11; boot_words = BOOT_WORDS_11; end
         2'b10: begin boot_start = BOOT_START_10; boot_words = BOOT_WORDS_10; end
         2'b01: begin boot_start = BOOT_START_01; boot_words = BOOT_WORDS_01; end
         default: begin boot_start = BOOT_START_00; boot_words = BOOT_WORDS_00; end
      endcase
   end

   // page base word of the pointer, region split
   assign op_word = {ptr[PTR_PAGE_MSB:PTR_PAGE_LSB], {WORD_SEL_WIDTH{1'b0}}}; // R3 R5
   assign op_no_read_while_write_region = (op_word >= NO_READ_WHILE_WRITE_REGION_FIRST_WORD); // R2

   // ==========================================================
   // axi write channel, address and data accepted in either order
   assign s_axi_awready = !aw_seen_r && !s_axi_bvalid;
   assign s_axi_wready  = !w_seen_r && !s_axi_bvalid;
   assign s_axi_bresp   = 2'b00;
   assign wr_go = aw_seen_r && w_seen_r && !s_axi_bvalid;

   always_ff @(posedge clk) begin
      if (rst) begin
         aw_seen_r <= 1'b0;
         w_seen_r <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
         s_axi_bvalid <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_seen_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_seen_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_seen_r <= 1'b0;
            w_seen_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   assign csr_wr = wr_go && awaddr_r == CSR_OFFSET && wstrb_r[0];
   assign sig_sel = wdata_r[BIT_SIGNATURE_READ] && wdata_r[4:0] == CMD_FILL; // R11
   assign cmd_in = sig_sel ? CMD_SIGNATURE : wdata_r[4:0];
   assign cmd_legal = sig_sel || cmd_in == CMD_REENABLE
                   || cmd_in == CMD_LOCK_SET || cmd_in == CMD_PAGE_WRITE
                   || cmd_in == CMD_PAGE_ERASE || cmd_in == CMD_FILL; // R22
   assign armed = state_r == ARMED_ST;

   // fuse configuration register
   always_ff @(posedge clk) begin
      if (rst)
         boot_fuse_r <= 2'b11;
      else if (wr_go && awaddr_r == FUSE_OFFSET && wstrb_r[0])
         boot_fuse_r <= wdata_r[1:0];
   end

   // interrupt enable bit
   always_ff @(posedge clk) begin
      if (rst)
         int_en_r <= 1'b0;
      else if (csr_wr)
         int_en_r <= wdata_r[BIT_READY_INT_ENABLE];
   end

   // ==========================================================
   // command sequencer
   assign op_done = state_r == BUSY_ST && op_cnt_r == 1;

   always_ff @(posedge clk) begin
      if (rst) begin
         state_r <= IDLE_ST;
         cmd_r <= 5'h00;
         arm_cnt_r <= 3'h0;
         op_cnt_r <= '0;
         op_no_read_while_write_region_r <= 1'b0;
      end else begin
         case (state_r)
            IDLE_ST: begin
               if (csr_wr && cmd_legal) begin // R22
                  state_r <= ARMED_ST;
                  cmd_r <= cmd_in;
                  arm_cnt_r <= ARM_CNT_LOAD;
               end
            end
            ARMED_ST: begin
               if (store_program_instr) begin
                  if (cmd_r == CMD_PAGE_WRITE || cmd_r == CMD_PAGE_ERASE) begin
                     state_r <= BUSY_ST; // R21
                     op_cnt_r <= ($clog2(OP_CYCLES+1))'(OP_CYCLES);
                     op_no_read_while_write_region_r <= op_no_read_while_write_region;
                  end else begin
                     state_r <= IDLE_ST; // R21
                     cmd_r <= 5'h00;
                  end
               end else if (arm_cnt_r == 3'h1) begin
                  state_r <= IDLE_ST; // R19
                  cmd_r <= 5'h00;
               end
               arm_cnt_r <= arm_cnt_r - 3'h1;
            end
            BUSY_ST: begin
               op_cnt_r <= op_cnt_r - 1'b1;
               if (op_done) begin
                  state_r <= IDLE_ST;
                  cmd_r <= 5'h00;
               end
            end
            default: state_r <= IDLE_ST;
         endcase
      end
   end

   // ==========================================================
   // region busy flag, set wins over clear
   always_ff @(posedge clk) begin
      if (rst)
         busy_r <= 1'b0;
      else if (armed && store_program_instr && !op_no_read_while_write_region
               && (cmd_r == CMD_PAGE_WRITE || cmd_r == CMD_PAGE_ERASE))
         busy_r <= 1'b1; // R9
      else if (armed && store_program_instr
               && (cmd_r == CMD_REENABLE || cmd_r == CMD_FILL))
         busy_r <= 1'b0; // R10 R12
   end

   // buffer fill tracking; re-enable write aborts it
   always_ff @(posedge clk) begin
      if (rst)
         fill_act_r <= 1'b0;
      else if (csr_wr && cmd_legal && cmd_in == CMD_REENABLE && state_r == IDLE_ST)
         fill_act_r <= 1'b0; // R13
      else if (armed && store_program_instr && cmd_r == CMD_FILL)
         fill_act_r <= 1'b1;
      else if (armed && store_program_instr && cmd_r == CMD_PAGE_WRITE)
         fill_act_r <= 1'b0;
   end
   assign buf_discard = csr_wr && cmd_legal && cmd_in == CMD_REENABLE
                        && state_r == IDLE_ST && fill_act_r; // R13

   // boot lock bits
   always_ff @(posedge clk) begin
      if (rst)
         lock_r <= LOCK_RESET;
      else if (armed && store_program_instr && cmd_r == CMD_LOCK_SET)
         lock_r <= lock_r & low_data_reg; // R14
   end

   // ==========================================================
   // flash array strobes
   always_ff @(posedge clk) begin
      if (rst) begin
         flash_erase <= 1'b0;
         flash_write <= 1'b0;
         buf_write <= 1'b0;
         page_number_bits <= '0;
         word_in_page_bits <= '0;
         buf_data <= 16'h0000;
      end else begin
         flash_erase <= armed && store_program_instr && cmd_r == CMD_PAGE_ERASE; // R17
         flash_write <= armed && store_program_instr && cmd_r == CMD_PAGE_WRITE; // R16
         buf_write <= armed && store_program_instr && cmd_r == CMD_FILL; // R20
         if (armed && store_program_instr) begin // R24
            page_number_bits <= ptr[PTR_PAGE_MSB:PTR_PAGE_LSB]; // R5
            word_in_page_bits <= ptr[PTR_WORD_MSB:PTR_WORD_LSB]; // R4 R7
            buf_data <= {high_data_reg, low_data_reg}; // R20
         end
      end
   end

   // load answers: signature, lock or fuse
   always_ff @(posedge clk) begin
      if (rst) begin
         load_data <= 8'h00;
         load_valid <= 1'b0;
      end else begin
         load_valid <= 1'b0;
         if (armed && load_program_instr && arm_cnt_r != 3'h1) begin
            if (cmd_r == CMD_SIGNATURE) begin
               load_data <= signature_byte; // R11
               load_valid <= 1'b1;
            end else if (cmd_r == CMD_LOCK_SET) begin
               load_data <= ptr[0] ? fuse_low_byte : lock_r; // R15
               load_valid <= 1'b1;
            end
         end
      end
   end

   assign core_stall = state_r == BUSY_ST && op_no_read_while_write_region_r; // R18
   assign ready_irq = int_en_r && global_int_flag && state_r == IDLE_ST; // R8
   assign region_read_block = busy_r && fetch_addr <= RWW_LAST_WORD; // R9

   // ==========================================================
   // axi read channel
   assign s_axi_arready = !s_axi_rvalid;
   assign s_axi_rresp = 2'b00;
   always_ff @(posedge clk) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         case (s_axi_araddr)
            CSR_OFFSET: s_axi_rdata <= {24'h000000, int_en_r, busy_r, 1'b0,
                                        cmd_r[4:1], state_r != IDLE_ST};
            FUSE_OFFSET: s_axi_rdata <= {30'h0000_0000, boot_fuse_r};
            STATUS_OFFSET: s_axi_rdata <= {3'h0, boot_words, boot_start};
            default: s_axi_rdata <= 32'h0000_0000;
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ==========================================================
   // checks
   a_arm_timeout: assert property (@(posedge clk) disable iff (rst)
      (armed && !store_program_instr [*4]) |=> !armed) // R19
      else $error("arming window did not close");
   a_enable_held: assert property (@(posedge clk) disable iff (rst)
      (state_r == BUSY_ST && !op_done) |=> state_r == BUSY_ST) // R21
      else $error("enable dropped during flash operation");
   a_no_read_while_write_region_stall: assert property (@(posedge clk) disable iff (rst)
      (armed && store_program_instr && (cmd_r == CMD_PAGE_ERASE || cmd_r == CMD_PAGE_WRITE)
      && op_no_read_while_write_region) |=> core_stall) // R18
      else $error("no stall for no_read_while_write_region operation");
   a_busy_set: assert property (@(posedge clk) disable iff (rst)
      (armed && store_program_instr && cmd_r == CMD_PAGE_WRITE && !op_no_read_while_write_region)
      |=> busy_r) // R9
      else $error("busy flag not set");
   a_busy_clr: assert property (@(posedge clk) disable iff (rst)
      (armed && store_program_instr && cmd_r == CMD_FILL) |=> !busy_r) // R10
      else $error("busy flag not cleared by fill");
   a_illegal_cmd: assert property (@(posedge clk) disable iff (rst)
      (csr_wr && !cmd_legal && state_r == IDLE_ST) |=> state_r == IDLE_ST) // R22
      else $error("illegal pattern armed");
   a_irq_ready: assert property (@(posedge clk) disable iff (rst)
      (int_en_r && global_int_flag && !armed && state_r != BUSY_ST) |-> ready_irq) // R8
      else $error("ready interrupt missing");
   a_lock_load: assert property (@(posedge clk) disable iff (rst)
      (armed && load_program_instr && cmd_r == CMD_LOCK_SET && arm_cnt_r != 3'h1)
      |=> load_valid) // R15
      else $error("lock read not answered");
   a_fill_write: assert property (@(posedge clk) disable iff (rst)
      (armed && store_program_instr && cmd_r == CMD_FILL)
      |=> buf_write && buf_data == {$past(high_data_reg), $past(low_data_reg)}) // R20
      else $error("buffer word not written");

endmodule

// [core_model.sv]
// processor core model issuing store and load instruction strobes
`timescale 1ns/100ps
module core_model (
   // clock
   input  wire logic        clk,
   // instruction strobes toward the block
   output logic             store_program_instr,
   output logic             load_program_instr,
   output logic [16:0]      ptr,
   output logic [7:0]       low_data_reg,
   output logic [7:0]       high_data_reg,
   // answer from the block
   input  wire logic        core_stall
);
   // idle levels from time zero
   initial begin
      store_program_instr = 1'b0;
      load_program_instr = 1'b0;
      ptr = 17'h0;
      low_data_reg = 8'h00;
      high_data_reg = 8'h00;
   end

   // ==========================================================
   // one instruction: a single-cycle strobe, payload scrambled after
   task automatic strobe(input logic st, input logic [16:0] p, input logic [15:0] d);
      while (core_stall) @(posedge clk);
      store_program_instr <= st;
      load_program_instr <= !st;
      ptr <= st ? {p[16:1], 1'b0} : p;
      {high_data_reg, low_data_reg} <= d;
      @(posedge clk);
      store_program_instr <= 1'b0;
      load_program_instr <= 1'b0;
      ptr <= ~p;
      {high_data_reg, low_data_reg} <= ~d;
   endtask
endmodule

// [flash_self_program_control_tb.sv]
// self-checking bench for the flash self-programming control block
`timescale 1ns/100ps
module flash_self_program_control_tb;
   import flash_self_program_pkg::*;
   typedef struct {string name; logic [31:0] val;} note_type;
   localparam int OPS = 12;
   logic        clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, st, ld, gie, stall, lvalid;
   logic        irq, rblock, fer, fwr, bwr, disc;
   logic [7:0]  awaddr, araddr, lo, hi, ldata;
   logic [31:0] wdata, rdata, seed, d;
   logic [1:0]  bresp, rresp;
   logic [16:0] ptr;
   logic [15:0] fetch, bdata;
   logic [8:0]  page;
   logic [6:0]  word;
   logic [7:0]  cmd;
   int          errors, comparisons, discards;
   note_type    notes[$];
   logic [7:0]  bad[5] = '{8'h07, 8'h0F, 8'h13, 8'h1F, 8'h10};

   flash_self_program_control #(.OP_CYCLES(OPS)) dut (
      .clk(clk), .rst(rst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .store_program_instr(st), .load_program_instr(ld), .ptr(ptr),
      .low_data_reg(lo), .high_data_reg(hi), .global_int_flag(gie),
      .fetch_addr(fetch), .core_stall(stall), .load_data(ldata),
      .load_valid(lvalid), .ready_irq(irq), .region_read_block(rblock),
      .flash_erase(fer), .flash_write(fwr), .page_number_bits(page),
      .buf_write(bwr), .word_in_page_bits(word), .buf_data(bdata),
      .buf_discard(disc), .signature_byte(8'h3C), .fuse_low_byte(8'h5A),
      .fuse_high_byte(8'hC3));

   core_model core (
      .clk(clk), .store_program_instr(st), .load_program_instr(ld), .ptr(ptr),
      .low_data_reg(lo), .high_data_reg(hi), .core_stall(stall));

   // ==========================================================
   // helpers
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [31:0] boot_status(input logic [1:0] c);
      logic [12:0] words;
      words = 13'h0200 << (2'd3 - c);
      return {3'h0, words, 16'h0 - {3'h0, words}};
   endfunction

   task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic expect_note(input string n, input logic [31:0] v);
      notes.push_back('{n, v});
   endtask

   task automatic take(input string n, input logic [31:0] g);
      note_type x;
      x = '{"none", 32'h0};
      if (notes.size() > 0) x = notes.pop_front();
      if (x.name != n) x.val = ~g;
      check(n, x.val, g);
   endtask

   task automatic axi_write(input logic [7:0] a, input logic [31:0] v);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge clk);
         if (!aw_ok && awready) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_ok && wready) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge clk); while (!bvalid);
      bready <= 1'b0;
   endtask

   task automatic axi_read(input logic [7:0] a, input logic [31:0] e);
      expect_note("read", e);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge clk); while (!rvalid);
      rready <= 1'b0;
   endtask

   task automatic complete_run();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // ==========================================================
   // clock and watchdog
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   initial begin
      #400000;
      errors++;
      complete_run();
   end

   // result watcher: every read, load, fill and flash result takes the oldest note; discards are only counted
   always @(posedge clk) begin
      if (rvalid && rready) take("read", rdata);
      if (lvalid) take("load", {24'h0, ldata});
      if (bwr) take("fill", {9'h0, word, bdata});
      if (fer || fwr) take("flash", {21'h0, fwr, fer, page});
      if (disc) discards++;
   end

   // ==========================================================
   // main sequence
   initial begin
      {awvalid, wvalid, bready, arvalid, rready, gie} = '0;
      {awaddr, araddr, wdata, fetch} = '0;
      {errors, comparisons, discards} = '0;
      seed = 32'd79;
      rst = 1'b1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      axi_read(CSR_OFFSET, 32'h0);
      axi_read(FUSE_OFFSET, 32'h3);
      axi_read(8'h0C, 32'h0);
      for (int c = 0; c < 4; c++) begin
         axi_write(FUSE_OFFSET, 32'(c));
         axi_read(STATUS_OFFSET, boot_status(2'(c)));
      end
      foreach (bad[i]) begin
         axi_write(CSR_OFFSET, {24'h0, bad[i]});
         axi_read(CSR_OFFSET, 32'h0);
      end
      // fill one random word, then re-enable while loaded
      d = rnd();
      axi_write(CSR_OFFSET, 32'h01);
      expect_note("fill", {9'h0, d[22:16], d[15:0]});
      core.strobe(1'b1, d[32-1:15], d[15:0]);
      axi_read(CSR_OFFSET, 32'h0);
      axi_write(CSR_OFFSET, 32'h11);
      core.strobe(1'b1, 17'h0, 16'h0);
      check("discard", 32'h1, 32'(discards > 0));
      // erase then write of a region page, ready interrupt around them
      axi_write(CSR_OFFSET, 32'h80);
      gie <= 1'b1;
      @(posedge clk);
      check("irq", 32'h1, 32'(irq));
      for (int k = 0; k < 2; k++) begin
         cmd = (k == 0) ? 8'h83 : 8'h85;
         axi_write(CSR_OFFSET, {24'h0, cmd});
         expect_note("flash", {21'h0, k[0], !k[0], 9'h0A5});
         core.strobe(1'b1, {9'h0A5, 8'h00}, rnd());
         fetch <= 16'hEFFF;
         @(posedge clk);
         check("block", 32'h1, 32'(rblock));
         check("irq", 32'h0, 32'(irq));
         fetch <= 16'hF000;
         @(posedge clk);
         check("block", 32'h0, 32'(rblock));
         axi_write(CSR_OFFSET, 32'h91);
         core.strobe(1'b1, 17'h0, 16'h0);
         axi_read(CSR_OFFSET, {24'h0, cmd | 8'h40});
         repeat (OPS + 2) @(posedge clk);
         axi_read(CSR_OFFSET, 32'hC0);
         if (k == 0) begin
            axi_write(CSR_OFFSET, 32'h91);
            core.strobe(1'b1, 17'h0, 16'h0);
         end else begin
            expect_note("fill", {9'h0, 7'h00, 16'h1234});
            axi_write(CSR_OFFSET, 32'h81);
            core.strobe(1'b1, 17'h0, 16'h1234);
         end
         axi_read(CSR_OFFSET, 32'h80);
         check("irq", 32'h1, 32'(irq));
      end
      // page write to the no-read-while-write region stalls the core
      axi_write(CSR_OFFSET, 32'h85);
      expect_note("flash", {21'h0, 2'b10, 9'h1E0});
      core.strobe(1'b1, {9'h1E0, 8'h00}, rnd());
      @(posedge clk);
      check("stall", 32'h1, 32'(stall));
      check("block", 32'h0, 32'(rblock));
      repeat (OPS + 2) @(posedge clk);
      check("stall", 32'h0, 32'(stall));
      // store arriving after the arming window does nothing
      axi_write(CSR_OFFSET, 32'h85);
      repeat (4) @(posedge clk);
      core.strobe(1'b1, {9'h1E0, 8'h00}, 16'h0);
      axi_read(CSR_OFFSET, 32'h80);
      // lock and fuse reads, lock set, signature read
      axi_write(CSR_OFFSET, 32'h89);
      expect_note("load", 32'h5A);
      core.strobe(1'b0, 17'h1, 16'h0);
      repeat (4) @(posedge clk);
      axi_write(CSR_OFFSET, 32'h89);
      core.strobe(1'b1, 17'h1FFFF, 16'hFFF0);
      axi_write(CSR_OFFSET, 32'h89);
      expect_note("load", 32'hF0);
      core.strobe(1'b0, 17'h0, 16'h0);
      repeat (4) @(posedge clk);
      axi_write(CSR_OFFSET, 32'hA1);
      expect_note("load", 32'h3C);
      core.strobe(1'b0, 17'h0, 16'h0);
      repeat (4) @(posedge clk);
      axi_write(CSR_OFFSET, 32'hA1);
      core.strobe(1'b1, {9'h0A5, 8'h00}, 16'h0);
      axi_read(CSR_OFFSET, 32'h80);
      repeat (5) @(posedge clk);
      check("pending", 32'h0, 32'(notes.size()));
      complete_run();
   end
endmodule
